/* File: rtl/wdit_map.svh */
// constants for the watchdog interval timer: keys, field positions, resets
`ifndef WDIT_MAP_SVH
`define WDIT_MAP_SVH
`define WDIT_KEY_WRITE     8'h5a
`define WDIT_KEY_READ      8'h69
`define WDIT_CTL_RESET     8'h00
`define WDIT_TAP_LSB       0
`define WDIT_TAP_MSB       1
`define WDIT_MODE_BIT      4
`define WDIT_CNT_CLR_BIT   3
`define WDIT_CLK_SEL_BIT   2
`define WDIT_HOLD_BIT      7
`define WDIT_NMI_SEL_BIT   5
`define WDIT_NMI_EDGE_BIT  6
`define WDIT_VECTOR_ADDR   16'hfffe
`define WDIT_CNT_WIDTH     16
`define WDIT_TAP0          15
`define WDIT_TAP1          13
`define WDIT_TAP2          9
`define WDIT_TAP3          6
`endif

/* File: rtl/wdit_pkg.sv */
// types shared by the watchdog interval timer
package wdit_pkg;
  typedef enum logic [1:0] {
    WDIT_RUN   = 2'b00,
    WDIT_FIRE  = 2'b01,
    WDIT_RESET = 2'b11
  } wdit_state_type;
endpackage : wdit_pkg

/* File: rtl/wdit_top.sv */
// watchdog / interval timer with keyed control word and flags
`include "wdit_map.svh"
module wdit_top #(
  parameter int CNT_WIDTH = `WDIT_CNT_WIDTH
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        por_i,
  input  wire logic        aux_tick_i,
  input  wire logic        ctl_wr_i,
  input  wire logic [15:0] ctl_wdata_i,
  output logic      [15:0] ctl_rdata_o,
  input  wire logic        rst_nmi_pin_i,
  input  wire logic        irq_enable_wr_i,
  input  wire logic        irq_enable_wdata_i,
  input  wire logic        irq_flag_wr_i,
  input  wire logic        irq_flag_wdata_i,
  input  wire logic        nmi_flag_wr_i,
  input  wire logic        nmi_flag_wdata_i,
  input  wire logic        irq_ack_i,
  output logic             watchdog_irq_enable_o,
  output logic             watchdog_irq_flag_o,
  output logic             nmi_pin_flag_o,
  output logic             irq_o,
  output logic             nmi_o,
  output logic             pin_reset_o,
  output logic             power_up_clear_o,
  output logic      [15:0] reset_vector_o
);

  ////////////////////////////////////////////////////////////////////////////
  // control word

  logic [7:0]           ctl_reg;
  logic [CNT_WIDTH-1:0] watchdog_counter_reg;
  logic                 puc_reg;
  logic                 pin_reg;
  logic                 key_ok;
  logic                 key_bad;
  logic                 tick;
  logic                 expire;
  logic                 tap_bit;
  logic                 pin_event;
  logic                 pin_reset;
  logic                 hard_clear;
  wdit_pkg::wdit_state_type state_reg;

  assign key_ok  = ctl_wr_i && (ctl_wdata_i[15:8] == `WDIT_KEY_WRITE);
  assign key_bad = ctl_wr_i && (ctl_wdata_i[15:8] != `WDIT_KEY_WRITE);

  // system reset, power-on and the pin reset wipe the control word and counter; puc_reg wipes them too
  assign hard_clear = sys_rst_i || por_i || pin_reset;

  always_ff @(posedge sys_clk_i) begin
    if (hard_clear || puc_reg) begin
      ctl_reg <= `WDIT_CTL_RESET;
    end else if (key_ok) begin
      ctl_reg <= ctl_wdata_i[7:0];
    end else begin
      ctl_reg[`WDIT_CNT_CLR_BIT] <= 1'b0;
    end
  end

  // key readback hides the write key; the upper byte always reads WDIT_KEY_READ
  assign ctl_rdata_o = {`WDIT_KEY_READ, ctl_reg};

  ////////////////////////////////////////////////////////////////////////////
  // counter and tap

  assign tick = ctl_reg[`WDIT_CLK_SEL_BIT] ? aux_tick_i : 1'b1;

  always_ff @(posedge sys_clk_i) begin
    if (hard_clear || puc_reg || expire ||
        (key_ok && ctl_wdata_i[`WDIT_CNT_CLR_BIT])) begin
      watchdog_counter_reg <= '0;
    end else if (tick && !ctl_reg[`WDIT_HOLD_BIT]) begin
      watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
    end
  end

  // tap index chosen by the two low control bits
  always_comb begin
    case (ctl_reg[`WDIT_TAP_MSB:`WDIT_TAP_LSB])
      2'd0:    tap_bit = watchdog_counter_reg[`WDIT_TAP0];
      2'd1:    tap_bit = watchdog_counter_reg[`WDIT_TAP1];
      2'd2:    tap_bit = watchdog_counter_reg[`WDIT_TAP2];
      default: tap_bit = watchdog_counter_reg[`WDIT_TAP3];
    endcase
  end

  assign expire = tap_bit && !puc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // power-up clear sequencer

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || por_i) begin
      state_reg <= wdit_pkg::WDIT_RUN;
    end else begin
      case (state_reg)
        wdit_pkg::WDIT_RUN: begin
          if (key_bad) begin
            state_reg <= wdit_pkg::WDIT_FIRE;
          end else if (expire && !ctl_reg[`WDIT_MODE_BIT]) begin
            state_reg <= wdit_pkg::WDIT_FIRE;
          end
        end
        wdit_pkg::WDIT_FIRE:  state_reg <= wdit_pkg::WDIT_RESET;
        wdit_pkg::WDIT_RESET: state_reg <= wdit_pkg::WDIT_RUN;
        default:              state_reg <= wdit_pkg::WDIT_RUN;
      endcase
    end
  end

  // one-cycle clear pulse; in timer mode only a bad key reaches here
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || por_i) begin
      puc_reg <= 1'b0;
    end else begin
      puc_reg <= (state_reg == wdit_pkg::WDIT_FIRE);
    end
  end

  assign power_up_clear_o = puc_reg;
  assign reset_vector_o   = `WDIT_VECTOR_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // reset/nmi pin

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= rst_nmi_pin_i;
    end
  end

  // edge select picks which transition counts as the nmi event
  assign pin_event = ctl_reg[`WDIT_NMI_SEL_BIT] &&
                     (ctl_reg[`WDIT_NMI_EDGE_BIT] ?
                       (pin_reg && !rst_nmi_pin_i) :
                       (!pin_reg && rst_nmi_pin_i));
  // in reset function the low pin level holds the device in reset
  assign pin_reset = !ctl_reg[`WDIT_NMI_SEL_BIT] && !rst_nmi_pin_i;
  assign pin_reset_o = pin_reset;
  assign nmi_o = pin_event;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || por_i || puc_reg) begin
      nmi_pin_flag_o <= 1'b0;
    end else if (pin_event) begin
      nmi_pin_flag_o <= 1'b1;
    end else if (nmi_flag_wr_i) begin
      nmi_pin_flag_o <= nmi_flag_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special function bits; nmi_pin_flag_o, the third cell, sits with the pin logic

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || por_i || puc_reg) begin
      watchdog_irq_enable_o <= 1'b0;
    end else if (irq_enable_wr_i) begin
      watchdog_irq_enable_o <= irq_enable_wdata_i;
    end
  end

  // flag survives a watchdog clear so software can see the cause
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || por_i || pin_reset) begin
      watchdog_irq_flag_o <= 1'b0;
    end else if (expire || key_bad) begin
      watchdog_irq_flag_o <= 1'b1;
    end else if (irq_ack_i && ctl_reg[`WDIT_MODE_BIT]) begin
      watchdog_irq_flag_o <= 1'b0;
    end else if (irq_flag_wr_i) begin
      watchdog_irq_flag_o <= irq_flag_wdata_i;
    end
  end

  assign irq_o = watchdog_irq_flag_o && watchdog_irq_enable_o &&
                 ctl_reg[`WDIT_MODE_BIT];

endmodule : wdit_top

/* File: tb/wdit_checker.sv */
// port assertions for the watchdog interval timer
module wdit_checker (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        ctl_wr_i,
  input wire logic [15:0] ctl_wdata_i,
  input wire logic [15:0] ctl_rdata_o,
  input wire logic        rst_nmi_pin_i,
  input wire logic        watchdog_irq_enable_o,
  input wire logic        watchdog_irq_flag_o,
  input wire logic        nmi_pin_flag_o,
  input wire logic        nmi_o,
  input wire logic        irq_o,
  input wire logic        pin_reset_o,
  input wire logic        power_up_clear_o,
  input wire logic [15:0] reset_vector_o
);
  ////////////////////////////////////////
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic bad_key;
  assign bad_key = ctl_wr_i && ctl_wdata_i[15:8] != 8'h5a;
  read_key_a: assert property (ctl_rdata_o[15:8] == 8'h69)
    else $error("read key wrong");
  bad_puc_a: assert property (bad_key |-> ##2 power_up_clear_o)
    else $error("no clear after bad key");
  bad_flag_a: assert property (bad_key |=> watchdog_irq_flag_o)
    else $error("flag not set after bad key");
  puc_pulse_a: assert property (power_up_clear_o |=> !power_up_clear_o)
    else $error("clear pulse too long");
  puc_clears_a: assert property (power_up_clear_o |=>
    ctl_rdata_o[7:0] == 8'h00 && !watchdog_irq_enable_o && !nmi_pin_flag_o)
    else $error("state kept over clear");
  irq_gate_a: assert property (irq_o ==
    (watchdog_irq_flag_o && watchdog_irq_enable_o && ctl_rdata_o[4]))
    else $error("irq gating wrong");
  timer_quiet_a: assert property ($rose(watchdog_irq_flag_o)
    && ctl_rdata_o[4] && !$past(ctl_wr_i) |=> !power_up_clear_o)
    else $error("clear in timer mode");
  pin_fn_a: assert property (pin_reset_o ==
    (!ctl_rdata_o[5] && !rst_nmi_pin_i))
    else $error("pin reset wrong");
  vector_a: assert property (reset_vector_o == 16'hfffe)
    else $error("vector wrong");
  nmi_flag_a: assert property (nmi_o && !power_up_clear_o |=>
    nmi_pin_flag_o)
    else $error("nmi flag not set");
  cover property (power_up_clear_o);
  cover property (irq_o);
  cover property ($rose(nmi_pin_flag_o));
endmodule : wdit_checker

bind wdit_top wdit_checker i_wdit_checker (.sys_clk_i, .sys_rst_i,
  .ctl_wr_i, .ctl_wdata_i, .ctl_rdata_o, .rst_nmi_pin_i,
  .watchdog_irq_enable_o, .watchdog_irq_flag_o, .nmi_pin_flag_o, .nmi_o,
  .irq_o,
  .pin_reset_o, .power_up_clear_o, .reset_vector_o);

/* File: tb/wdit_top_tb.sv */
// self-checking bench for the watchdog interval timer
module wdit_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, sys_rst_i = 1, por_i = 0, aux_tick_i = 0;
  logic ctl_wr_i = 0, rst_nmi_pin_i = 1, irq_enable_wr_i = 0;
  logic irq_enable_wdata_i = 0, irq_flag_wr_i = 0, irq_flag_wdata_i = 0;
  logic nmi_flag_wr_i = 0, nmi_flag_wdata_i = 0, irq_ack_i = 0;
  logic [15:0] ctl_wdata_i = 16'h0000, ctl_rdata_o, reset_vector_o;
  logic watchdog_irq_enable_o, watchdog_irq_flag_o, nmi_pin_flag_o;
  logic irq_o, nmi_o, pin_reset_o, power_up_clear_o, wr_d = 0, none_due;
  logic [15:0] exp_rd[$];
  int n_mismatch = 0, n_compared = 0, seed = 74693, puc_due = 0;
  wdit_top #(.CNT_WIDTH(16)) i_wdit_top (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  always_comb none_due = puc_due == 0;
  ////////////////////////////////////////
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic print_verdict;
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // strobe stays up so back-to-back writes never reassign it in one step
  task automatic wr(logic [15:0] w);
    ctl_wr_i <= 1'b1;
    ctl_wdata_i <= w;
    // the counter-clear bit reads back as written for the cycle after
    if (w[15:8] == 8'h5a) exp_rd.push_back({8'h69, w[7:0]});
    else puc_due++;
    @(posedge sys_clk_i);
  endtask : wr
  task automatic idle(int n);
    {ctl_wr_i, irq_enable_wr_i, irq_flag_wr_i, nmi_flag_wr_i} <= 4'h0;
    irq_ack_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  task automatic wait_hi(ref logic s, input int n);
    while (s !== 1'b1 && n > 0) begin
      n--;
      idle(1);
    end
    if (s !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_hi
  ////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    wr_d <= ctl_wr_i && ctl_wdata_i[15:8] == 8'h5a;
    aux_tick_i <= 1'($random(seed));
    if (wr_d && exp_rd.size() > 0)
      cmp("ctl_rdata_o", exp_rd.pop_front(), ctl_rdata_o);
    if (power_up_clear_o) begin
      cmp("power_up_clear_o", 16'(puc_due > 0), 16'h0001);
      if (puc_due > 0) puc_due--;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    idle(1);
    for (int i = 0; i < 6; i++) wr({8'h5a, 8'h80 | 8'($random(seed))});
    wr(16'h69c1);
    idle(4);
    cmp("watchdog_irq_flag_o", 16'h0001, 16'(watchdog_irq_flag_o));
    cmp("ctl_rdata_o", 16'h6900, ctl_rdata_o);
    {irq_flag_wr_i, irq_flag_wdata_i} <= 2'b10;
    {irq_enable_wr_i, irq_enable_wdata_i} <= 2'b11;
    wr(16'h5a1b);
    wait_hi(irq_o, 100);
    {irq_ack_i, irq_enable_wr_i, irq_enable_wdata_i} <= 3'b110;
    @(posedge sys_clk_i);
    idle(70);
    cmp("irq_o", 16'h0000, 16'(irq_o));
    cmp("watchdog_irq_flag_o", 16'h0001, 16'(watchdog_irq_flag_o));
    // auxiliary clock select: expiry takes about twice as long
    puc_due++;
    wr(16'h5a0f);
    wait_hi(none_due, 400);
    wr(16'h5aa0);
    rst_nmi_pin_i <= 1'b0;
    idle(3);
    cmp("pin_reset_o", 16'h0000, 16'(pin_reset_o));
    rst_nmi_pin_i <= 1'b1;
    idle(3);
    cmp("nmi_pin_flag_o", 16'h0001, 16'(nmi_pin_flag_o));
    print_verdict();
  end
endmodule : wdit_top_tb
